/* design/abac_match.sv */
// Matcher for one memory unit: two block control words, one access
// Assumes the caller supplies stable words and the access fields.
`timescale 1ns/1ps
`include "abac_defs.svh"
module abac_match (
  input wire logic [31:0] ctl_zero,
  input wire logic [31:0] ctl_one,
  input wire logic [7:0] addr_hi,
  input wire logic privilege_code_bit,
  output abac_pkg::abac_attr_t attr
);
  import abac_pkg::*;

  logic [1:0] hit;
  logic [31:0] words [2];

  assign words[0] = ctl_zero;
  assign words[1] = ctl_one;

  // Per-register compare of base, mask, enable and privilege
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    logic [7:0] base;
    logic [7:0] mask;
    logic [1:0] priv;
    logic priv_ok;
    assign base = words[i][`ABAC_BASE_MSB:`ABAC_BASE_LSB];
    assign mask = words[i][`ABAC_MASK_MSB:`ABAC_MASK_LSB];
    assign priv = words[i][`ABAC_PRIV_MSB:`ABAC_PRIV_LSB];
    assign priv_ok = priv[1] | (priv[0] == privilege_code_bit); // [RQ7]
    assign hit[i] = words[i][`ABAC_EN_BIT] & priv_ok & // [RQ6] [RQ17]
      (((base ^ addr_hi) & ~mask) == 8'h00); // [RQ4] [RQ5]
  end

  // Register zero takes priority on overlap
  always_comb begin
    logic [31:0] sel;
    sel = hit[0] ? words[0] : words[1]; // [RQ2]
    attr.hit = |hit; // [RQ19]
    attr.uattr = hit != 2'b00 ? sel[`ABAC_UATTR_MSB:`ABAC_UATTR_LSB] : 2'b00;
    attr.cpol = hit != 2'b00 ? sel[`ABAC_CPOL_MSB:`ABAC_CPOL_LSB] : 2'b00;
    attr.wprot = (hit != 2'b00) & sel[`ABAC_WP_BIT];
  end

endmodule : abac_match

/* design/abac_top.sv */
// Block access control: four control words, AHB-Lite slave, two matchers
// Assumes one clock, AHB-Lite single-word transfers, hprot[1] privilege.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "abac_defs.svh"
module abac_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire abac_pkg::abac_access_t ifetch,
  input wire abac_pkg::abac_access_t dacc,
  output abac_pkg::abac_attr_t ifetch_attr_q,
  output abac_pkg::abac_attr_t dacc_attr_q,
  output abac_pkg::abac_action_t ifetch_act_q,
  output abac_pkg::abac_action_t dacc_act_q,
  output logic user_attr_pin_lo,
  output logic user_attr_pin_hi,
  output logic user_attr_pin_oe,
  output logic cache_inhibit_out_n,
  output logic cache_inhibit_oe,
  output logic access_err_q
);
  import abac_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [31:0] ctl_q [4];
  abac_state_t state_q;
  logic [1:0] widx_q;
  logic wr_q;
  logic wpriv_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic [1:0] aidx;
  logic take;

  assign take = hsel & hready & htrans[1];
  assign aidx = haddr[3:2];
  assign addr_ok = haddr[11:4] == 8'h00;

  // Address phase capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ABAC_ST_IDLE;
      widx_q <= 2'b00;
      wr_q <= 1'b0;
      wpriv_q <= 1'b0;
    end else if (hready) begin
      state_q <= take ? ABAC_ST_DATA : ABAC_ST_IDLE;
      widx_q <= aidx;
      wr_q <= take & hwrite & addr_ok;
      wpriv_q <= hprot[1];
    end
  end

  // Read data for the next data phase, supervisor only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (take & ~hwrite & addr_ok & hprot[1]) begin
      hrdata_q <= ctl_q[aidx]; // [RQ1]
    end else if (hready) begin
      hrdata_q <= 32'h0000_0000;
    end
  end

  // Control word writes; reset clears enables and all fields
  for (genvar r = 0; r < 4; r++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ctl_q[r] <= `ABAC_RST_VAL; // [RQ3]
      end else if (wr_q && wpriv_q && widx_q == 2'(r)) begin
        ctl_q[r] <= hwdata & `ABAC_WR_MASK; // [RQ1]
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Matching per memory unit

  abac_attr_t iattr;
  abac_attr_t dattr;

  // Instruction pair serves fetches only
  abac_match u_imatch (
    .ctl_zero(ctl_q[0]),
    .ctl_one(ctl_q[1]),
    .addr_hi(ifetch.addr[31:24]),
    .privilege_code_bit(ifetch.privilege_code_bit),
    .attr(iattr)
  ); // [RQ18]

  // Data pair serves operand accesses only
  abac_match u_dmatch (
    .ctl_zero(ctl_q[2]),
    .ctl_one(ctl_q[3]),
    .addr_hi(dacc.addr[31:24]),
    .privilege_code_bit(dacc.privilege_code_bit),
    .attr(dattr)
  ); // [RQ18]

  // Policy decode into cache actions
  function automatic abac_action_t decide(abac_access_t a, abac_attr_t t);
    abac_action_t r;
    logic wr;
    r = '0;
    wr = a.write | a.rmw;
    if (a.valid && t.hit) begin
      r.access_err = t.wprot & wr; // [RQ15] [RQ16]
      unique case (t.cpol)
        `ABAC_CP_WTHRU: begin
          r.use_cache = 1'b1; // [RQ9]
          r.fill_on_miss = ~wr & ~a.cache_hit;
          r.write_mem = wr; // [RQ9]
        end
        `ABAC_CP_CBACK: begin
          r.use_cache = 1'b1; // [RQ10]
          r.fill_on_miss = ~a.cache_hit;
          r.mark_dirty = wr; // [RQ10]
        end
        default: begin
          r.inhibit = 1'b1; // [RQ11]
          r.push_line = a.cache_hit & a.line_dirty; // [RQ12]
          r.inval_line = a.cache_hit & ~a.line_dirty; // [RQ12]
          r.serialize = (t.cpol == `ABAC_CP_SERIAL) & a.aligned; // [RQ13]
          r.no_interrupt = (t.cpol == `ABAC_CP_SERIAL) & a.aligned &
            ~wr; // [RQ14]
        end
      endcase
      if (r.access_err) begin
        r = '0;
        r.access_err = 1'b1;
      end
    end else if (a.valid) begin
      r.use_cache = 1'b1;
      r.fill_on_miss = ~a.cache_hit;
      r.mark_dirty = wr;
    end
    return r;
  endfunction : decide

  abac_action_t iact;
  abac_action_t dact;

  assign iact = decide(ifetch, iattr); // [RQ19]
  assign dact = decide(dacc, dattr); // [RQ19]

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Attributes and actions
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ifetch_attr_q <= '0;
      dacc_attr_q <= '0;
      ifetch_act_q <= '0;
      dacc_act_q <= '0;
      access_err_q <= 1'b0;
    end else begin
      ifetch_attr_q <= iattr;
      dacc_attr_q <= dattr;
      ifetch_act_q <= iact;
      dacc_act_q <= dact;
      access_err_q <= iact.access_err | dact.access_err; // [RQ16]
    end
  end

  logic d_ext;
  logic i_ext;
  assign d_ext = dacc.valid & dacc.ext_xfer & dattr.hit & ~dact.access_err;
  assign i_ext = ifetch.valid & ifetch.ext_xfer & iattr.hit &
    ~iact.access_err;

  // Attribute and inhibit pins, data unit first when both go out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      user_attr_pin_lo <= 1'b0;
      user_attr_pin_hi <= 1'b0;
      user_attr_pin_oe <= 1'b0;
      cache_inhibit_out_n <= 1'b1;
      cache_inhibit_oe <= 1'b0;
    end else if (d_ext) begin
      user_attr_pin_lo <= dattr.uattr[0]; // [RQ8]
      user_attr_pin_hi <= dattr.uattr[1]; // [RQ8]
      user_attr_pin_oe <= 1'b1;
      cache_inhibit_out_n <= ~dact.inhibit; // [RQ11]
      cache_inhibit_oe <= 1'b1;
    end else if (i_ext) begin
      user_attr_pin_lo <= iattr.uattr[0]; // [RQ8]
      user_attr_pin_hi <= iattr.uattr[1]; // [RQ8]
      user_attr_pin_oe <= 1'b1;
      cache_inhibit_out_n <= ~iact.inhibit; // [RQ11]
      cache_inhibit_oe <= 1'b1;
    end else begin
      user_attr_pin_lo <= 1'b0;
      user_attr_pin_hi <= 1'b0;
      user_attr_pin_oe <= 1'b0;
      cache_inhibit_out_n <= 1'b1;
      cache_inhibit_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_reset_clear;
    @(posedge clk_sys) $rose(rst_n) |->
      ctl_q[0][`ABAC_EN_BIT] == 1'b0 && ctl_q[1][`ABAC_EN_BIT] == 1'b0 &&
      ctl_q[2][`ABAC_EN_BIT] == 1'b0 && ctl_q[3][`ABAC_EN_BIT] == 1'b0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RQ3]
    else $error("enable bit not cleared by reset");

  property p_user_write_blocked;
    @(posedge clk_sys) disable iff (!rst_n)
      take && hwrite && !hprot[1] |=> ##1
      $stable(ctl_q[0]) && $stable(ctl_q[1]) &&
      $stable(ctl_q[2]) && $stable(ctl_q[3]);
  endproperty
  a_user_write_blocked: assert property (p_user_write_blocked) // [RQ1]
    else $error("user write changed a control word");

  property p_user_read_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      take && !hwrite && !hprot[1] |=> hrdata == 32'h0000_0000;
  endproperty
  a_user_read_zero: assert property (p_user_read_zero) // [RQ1]
    else $error("user read returned register data");

  property p_zero_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      u_dmatch.hit == 2'b11 |->
      dattr.cpol == ctl_q[2][`ABAC_CPOL_MSB:`ABAC_CPOL_LSB];
  endproperty
  a_zero_wins: assert property (p_zero_wins) // [RQ2]
    else $error("register one won an overlap");

  property p_disabled_nohit;
    @(posedge clk_sys) disable iff (!rst_n)
      !ctl_q[0][`ABAC_EN_BIT] && !ctl_q[1][`ABAC_EN_BIT] |-> !iattr.hit;
  endproperty
  a_disabled_nohit: assert property (p_disabled_nohit) // [RQ6]
    else $error("disabled registers produced a hit");

  property p_wp_abort;
    @(posedge clk_sys) disable iff (!rst_n)
      dacc.valid && dattr.hit && dattr.wprot && (dacc.write || dacc.rmw)
      |=> access_err_q && !dacc_act_q.write_mem;
  endproperty
  a_wp_abort: assert property (p_wp_abort) // [RQ15]
    else $error("protected write not aborted");

  property p_inhibit_pin;
    @(posedge clk_sys) disable iff (!rst_n)
      d_ext && dattr.cpol[1] |=> !cache_inhibit_out_n && cache_inhibit_oe;
  endproperty
  a_inhibit_pin: assert property (p_inhibit_pin) // [RQ11]
    else $error("inhibit pin not asserted");

  property p_uattr_pin;
    @(posedge clk_sys) disable iff (!rst_n)
      d_ext |=> {user_attr_pin_hi, user_attr_pin_lo} == $past(dattr.uattr);
  endproperty
  a_uattr_pin: assert property (p_uattr_pin) // [RQ8]
    else $error("attribute pins differ from register");

  property p_copyback_dirty;
    @(posedge clk_sys) disable iff (!rst_n)
      dacc.valid && dattr.hit && dattr.cpol == `ABAC_CP_CBACK &&
      dacc.write && !dattr.wprot |=> dacc_act_q.mark_dirty &&
      !dacc_act_q.write_mem;
  endproperty
  a_copyback_dirty: assert property (p_copyback_dirty) // [RQ10]
    else $error("copyback write went to memory");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      !(take && !hwrite && addr_ok && hprot[1]) |=>
      hrdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // [RQ1]
    else $error("read data shown outside a read data phase");

  property p_zero_wins_i;
    @(posedge clk_sys) disable iff (!rst_n)
      u_imatch.hit == 2'b11 |->
      iattr.uattr == ctl_q[0][`ABAC_UATTR_MSB:`ABAC_UATTR_LSB];
  endproperty
  a_zero_wins_i: assert property (p_zero_wins_i) // [RQ2]
    else $error("instruction register one won an overlap");

  property p_ddisabled_nohit;
    @(posedge clk_sys) disable iff (!rst_n)
      !ctl_q[2][`ABAC_EN_BIT] && !ctl_q[3][`ABAC_EN_BIT] |-> !dattr.hit;
  endproperty
  a_ddisabled_nohit: assert property (p_ddisabled_nohit) // [RQ17]
    else $error("disabled data registers produced a hit");

  property p_wthru_write;
    @(posedge clk_sys) disable iff (!rst_n)
      dacc.valid && dattr.hit && dattr.cpol == `ABAC_CP_WTHRU &&
      dacc.write && !dattr.wprot |=> dacc_act_q.write_mem &&
      dacc_act_q.use_cache && !dacc_act_q.mark_dirty;
  endproperty
  a_wthru_write: assert property (p_wthru_write) // [RQ9]
    else $error("writethrough write skipped memory");

  property p_inhibit_push;
    @(posedge clk_sys) disable iff (!rst_n)
      dacc.valid && dattr.hit && dattr.cpol[1] && dacc.cache_hit &&
      !dact.access_err |=>
      dacc_act_q.push_line == $past(dacc.line_dirty) &&
      dacc_act_q.inval_line == !$past(dacc.line_dirty) &&
      !dacc_act_q.use_cache;
  endproperty
  a_inhibit_push: assert property (p_inhibit_push) // [RQ12]
    else $error("held line not pushed or invalidated");

  property p_serial;
    @(posedge clk_sys) disable iff (!rst_n)
      dacc.valid && dattr.hit && dattr.cpol == `ABAC_CP_SERIAL &&
      dacc.aligned && !dacc.write && !dacc.rmw |=>
      dacc_act_q.serialize && dacc_act_q.no_interrupt;
  endproperty
  a_serial: assert property (p_serial) // [RQ13] [RQ14]
    else $error("serialized read not protected");

  property p_pin_release;
    @(posedge clk_sys) disable iff (!rst_n)
      !d_ext && !i_ext |=> !user_attr_pin_oe && !cache_inhibit_oe &&
      cache_inhibit_out_n;
  endproperty
  a_pin_release: assert property (p_pin_release) // [RQ8]
    else $error("pins driven without a bus transfer");

  c_overlap: cover property (@(posedge clk_sys) u_imatch.hit == 2'b11);
  c_abort: cover property (@(posedge clk_sys) access_err_q);
  c_serial: cover property (@(posedge clk_sys) dacc_act_q.serialize);
  c_push: cover property (@(posedge clk_sys) dacc_act_q.push_line);
  c_copyback: cover property (@(posedge clk_sys) dacc_act_q.mark_dirty);

endmodule : abac_top

/* dv/abac_core_model.sv */
// Core model: instruction and data units, one access a cycle on one unit at a time
// Assumes callers invoke its tasks right after a rising clock edge.
`timescale 1ns/1ps
module abac_core_model (
  input wire logic clk_sys,
  output abac_pkg::abac_access_t ifetch,
  output abac_pkg::abac_access_t dacc
);
  import abac_pkg::*;
  ////////////////////////////////////////
  // Both units quiet at time zero
  initial begin
    ifetch = '0;
    dacc = '0;
  end
  // Drop an access; flip the address so it differs from the last one in every bit
  function automatic abac_access_t quiet(input abac_access_t a);
    abac_access_t q;
    q = a;
    q.valid = 1'b0;
    q.ext_xfer = 1'b0;
    q.addr = ~a.addr;
    return q;
  endfunction : quiet
  // One access on the chosen unit, the other unit quiet
  task automatic present(input logic inst, input abac_access_t a);
    ifetch <= inst ? a : quiet(ifetch);
    dacc <= inst ? quiet(dacc) : a;
  endtask : present
  // Both units quiet from the next edge
  task automatic rest();
    ifetch <= quiet(ifetch);
    dacc <= quiet(dacc);
  endtask : rest
endmodule : abac_core_model

/* dv/tb.sv */
// Bench for block access control: registers, matching, actions
// Assumes abac_pkg, abac_top and abac_core_model compile first.
`timescale 1ns/1ps
`include "abac_defs.svh"
`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); \
  end \
end
module tb;
  import abac_pkg::*;
  typedef struct packed {
    logic inst;
    logic [31:0] c0;
    logic [31:0] c1;
    logic [31:0] addr;
    logic privilege_code_bit;
    logic write;
    abac_attr_t exp;
  } abac_row_t;
  logic clk_sys;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [3:0] hprot;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] wx;
  logic hreadyout;
  logic hresp;
  logic ci_oe;
  abac_access_t ifetch;
  abac_access_t dacc;
  abac_access_t acc;
  abac_attr_t i_attr;
  abac_attr_t d_attr;
  abac_attr_t got;
  abac_action_t d_act;
  abac_action_t i_act;
  logic pin_lo;
  logic pin_hi;
  logic pin_oe;
  logic ci_n;
  logic err_q;
  abac_row_t rows[14];
  int bad_count;
  int samples_checked;
  int cycles;
  ////////////////////////////////////////
  // Device and core model
  abac_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hprot(hprot),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ifetch(ifetch), .dacc(dacc),
    .ifetch_attr_q(i_attr), .dacc_attr_q(d_attr), .ifetch_act_q(i_act),
    .dacc_act_q(d_act), .user_attr_pin_lo(pin_lo),
    .user_attr_pin_hi(pin_hi), .user_attr_pin_oe(pin_oe),
    .cache_inhibit_out_n(ci_n), .cache_inhibit_oe(ci_oe), .access_err_q(err_q)
  );
  abac_core_model core (.clk_sys(clk_sys), .ifetch(ifetch), .dacc(dacc));
  ////////////////////////////////////////
  // Clock at 25 ns
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      summarize();
    end
  end
  // Verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [31:0] a,
      input logic [31:0] wd, input logic [3:0] pr);
    if (clk_sys !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hprot <= pr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Load all four control words
  task automatic cfg(input logic [31:0] i0, i1, d0, d1);
    bus(1'b1, 32'h0000_0000, i0, 4'h3);
    bus(1'b1, 32'h0000_0004, i1, 4'h3);
    bus(1'b1, 32'h0000_0008, d0, 4'h3);
    bus(1'b1, 32'h0000_000C, d1, 4'h3);
  endtask : cfg
  // Present one access, results settled at the following negedge
  task automatic probe(input logic inst, input abac_access_t a);
    if (clk_sys !== 1'b1) @(posedge clk_sys);
    core.present(inst, a);
    @(posedge clk_sys);
    core.rest();
    @(negedge clk_sys);
  endtask : probe
  // Enabled control word
  function automatic logic [31:0] w(input logic [7:0] b, m,
      input logic [1:0] s, u, c, input logic p);
    return {b, m, 1'b1, s, 3'h0, u, 1'b0, c, 2'h0, p, 2'h0};
  endfunction : w
  // Aligned access with a bus transfer
  function automatic abac_access_t mk(input logic [31:0] a,
      input logic s, wr, h, d);
    return '{1'b1, a, s, wr, 1'b0, 1'b1, 1'b1, h, d};
  endfunction : mk
  ////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hprot = 4'h3;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    wx = w(8'h00, 8'hFF, 2'h2, 2'h3, 2'h3, 1'b1);
    rows = '{
      '{1'b0, w(8'h12, 8'h00, 2'h2, 2'h2, 2'h0, 1'b0), 32'h0,
        32'h1234_5678, 1'b0, 1'b0, 6'h30},
      '{1'b0, w(8'h12, 8'h00, 2'h2, 2'h2, 2'h0, 1'b0), 32'h0,
        32'h1334_0000, 1'b1, 1'b0, 6'h00},
      '{1'b0, w(8'h12, 8'h81, 2'h3, 2'h1, 2'h1, 1'b0), 32'h0,
        32'h9300_0000, 1'b0, 1'b0, 6'h2A},
      '{1'b0, w(8'h12, 8'h81, 2'h3, 2'h1, 2'h1, 1'b0), 32'h0,
        32'h1600_0000, 1'b1, 1'b0, 6'h00},
      '{1'b0, w(8'h12, 8'h00, 2'h2, 2'h1, 2'h0, 1'b0) ^ 32'h0000_8000,
        32'h0, 32'h1200_0000, 1'b1, 1'b0, 6'h00},
      '{1'b0, w(8'h40, 8'h0F, 2'h0, 2'h3, 2'h2, 1'b0), 32'h0,
        32'h4500_0000, 1'b0, 1'b0, 6'h3C},
      '{1'b0, w(8'h40, 8'h0F, 2'h0, 2'h3, 2'h2, 1'b0), 32'h0,
        32'h4500_0000, 1'b1, 1'b0, 6'h00},
      '{1'b0, w(8'h40, 8'h0F, 2'h1, 2'h3, 2'h2, 1'b0), 32'h0,
        32'h4500_0000, 1'b1, 1'b0, 6'h3C},
      '{1'b0, w(8'h40, 8'h0F, 2'h1, 2'h3, 2'h2, 1'b0), 32'h0,
        32'h4500_0000, 1'b0, 1'b0, 6'h00},
      '{1'b0, w(8'h40, 8'h0F, 2'h3, 2'h3, 2'h2, 1'b0), 32'h0,
        32'h4500_0000, 1'b0, 1'b0, 6'h3C},
      '{1'b0, w(8'h20, 8'h01, 2'h2, 2'h1, 2'h3, 1'b0),
        w(8'h20, 8'h00, 2'h2, 2'h2, 2'h1, 1'b1),
        32'h2000_0000, 1'b1, 1'b1, 6'h2E},
      '{1'b0, 32'h0, w(8'h20, 8'h00, 2'h2, 2'h2, 2'h1, 1'b1),
        32'h2000_0000, 1'b1, 1'b1, 6'h33},
      '{1'b1, w(8'h80, 8'h00, 2'h2, 2'h1, 2'h0, 1'b0), 32'h0,
        32'h8000_0004, 1'b1, 1'b0, 6'h28},
      '{1'b1, w(8'h80, 8'h00, 2'h2, 2'h1, 2'h0, 1'b0), 32'h0,
        32'h7000_0000, 1'b1, 1'b0, 6'h00}};
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // Reset values, privilege filter on the bus, unmapped place
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 32'(i * 4), 32'h0, 4'h3);
      `CHK("reset word", `ABAC_RST_VAL, rd)
      bus(1'b1, 32'(i * 4), 32'hFFFF_FFFF, 4'h3);
      bus(1'b1, 32'(i * 4), 32'h0000_0000, 4'h1);
      bus(1'b0, 32'(i * 4), 32'h0, 4'h1);
      `CHK("user read", 32'h0000_0000, rd)
      bus(1'b0, 32'(i * 4), 32'h0, 4'h3);
      `CHK("super read", `ABAC_WR_MASK, rd)
      `CHK("resp", 1'b0, hresp)
    end
    bus(1'b1, 32'h0000_0010, 32'h0000_0000, 4'h3);
    bus(1'b0, 32'h0000_0010, 32'h0, 4'h3);
    `CHK("unmapped", 32'h0000_0000, rd)
    bus(1'b0, 32'h0000_0000, 32'h0, 4'h3);
    `CHK("no alias", `ABAC_WR_MASK, rd)
    // Matching rows; the unused pair matches everything
    foreach (rows[k]) begin
      if (rows[k].inst) cfg(rows[k].c0, rows[k].c1, wx, wx);
      else cfg(wx, wx, rows[k].c0, rows[k].c1);
      probe(rows[k].inst, mk(rows[k].addr, rows[k].privilege_code_bit,
                             rows[k].write, 1'b0, 1'b0));
      got = rows[k].inst ? i_attr : d_attr;
      `CHK("hit", rows[k].exp.hit, got.hit)
      if (rows[k].exp.hit) `CHK("attr", rows[k].exp, got)
      `CHK("err", rows[k].exp.wprot & rows[k].write, err_q)
      if (rows[k].inst) `CHK("ifill", 1'b1, i_act.fill_on_miss)
    end
    // Cache policy actions: write dirty hit, clean read hit, read miss
    for (int c = 0; c < 4; c++) begin
      cfg(wx, wx, w(8'h00, 8'hFF, 2'h2, 2'(c), 2'(c), 1'b0), 32'h0);
      for (int r = 0; r < 3; r++) begin
        probe(1'b0, mk(32'h5555_0000, 1'b1, r == 0, r != 2, r == 0));
        `CHK("use", c < 2, d_act.use_cache)
        `CHK("fill", c < 2 && r == 2, d_act.fill_on_miss)
        `CHK("wmem", r == 0 && c == 0, d_act.write_mem)
        `CHK("dirty", c == 1 && r == 0, d_act.mark_dirty)
        `CHK("inh", c > 1, d_act.inhibit)
        `CHK("ci_n", c < 2, ci_n)
        `CHK("push", c > 1 && r == 0, d_act.push_line)
        `CHK("inval", c > 1 && r == 1, d_act.inval_line)
        `CHK("ser", c == 2, d_act.serialize)
        `CHK("noint", c == 2 && r != 0, d_act.no_interrupt)
        `CHK("pins", 4'(c + 12), {ci_oe, pin_oe, pin_hi, pin_lo})
      end
    end
    // Write protect: read-modify-write aborts, plain read passes
    cfg(wx, wx, w(8'h00, 8'hFF, 2'h2, 2'h0, 2'h0, 1'b1), 32'h0);
    acc = mk(32'h0100_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    acc.rmw = 1'b1;
    probe(1'b0, acc);
    `CHK("rmw abort", 1'b1, err_q)
    `CHK("abort act", 1'b1, d_act.access_err)
    acc.rmw = 1'b0;
    probe(1'b0, acc);
    `CHK("read ok", 1'b0, err_q)
    // Reset in mid-run clears every enable
    cfg(wx, wx, wx, wx);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 32'(i * 4), 32'h0, 4'h3);
      `CHK("enable", 1'b0, rd[15])
    end
    summarize();
  end
endmodule : tb

/* inc/abac_defs.svh */
// Offsets, field positions and reset values of the block access control
// Assumes inclusion by the package and the design files by bare name.
// Notes on behaviour
// [RQ1] Four 32-bit registers, supervisor-only access
// [RQ2] Block at least 16 Mbytes; register zero wins
// [RQ3] Reset clears all four enable bits
// [RQ4] Base field compared with address bits 31:24
// [RQ5] Mask bits drop base bits from compare
// [RQ6] Enable bit turns access control off/on
// [RQ7] Privilege filter: 00 user, 01 super, 1x any
// [RQ8] User attribute bits driven onto attribute pins
// [RQ9] Mode 00 writethrough: read fill, write memory
// [RQ10] Mode 01 copyback: write hit sets dirty
// [RQ11] Mode 1x bypasses cache, inhibit asserted
// [RQ12] Inhibited access pushes dirty, invalidates clean
// [RQ13] Mode 10 serialized: program order, aligned only
// [RQ14] Serialized operand fetch blocks interruption
// [RQ15] Write protect aborts write and RMW accesses
// [RQ16] Protect abort raises access error
// [RQ17] Disabled register takes no part in matching
// [RQ18] Fetches use instruction pair, operands data pair
// [RQ19] Match and attributes computed combinationally
`ifndef ABAC_DEFS_SVH
`define ABAC_DEFS_SVH

// Register byte addresses on the bus
`define ABAC_OFF_IBC0 12'h000
`define ABAC_OFF_IBC1 12'h004
`define ABAC_OFF_DBC0 12'h008
`define ABAC_OFF_DBC1 12'h00C

// Field positions inside a block control word
`define ABAC_BASE_MSB 31
`define ABAC_BASE_LSB 24
`define ABAC_MASK_MSB 23
`define ABAC_MASK_LSB 16
`define ABAC_EN_BIT 15
`define ABAC_PRIV_MSB 14
`define ABAC_PRIV_LSB 13
`define ABAC_UATTR_MSB 9
`define ABAC_UATTR_LSB 8
`define ABAC_CPOL_MSB 6
`define ABAC_CPOL_LSB 5
`define ABAC_WP_BIT 2

// Writable bits and reset value
`define ABAC_WR_MASK 32'hFFFF_E364
`define ABAC_RST_VAL 32'h0000_0000

// Cache policy codes
`define ABAC_CP_WTHRU 2'h0
`define ABAC_CP_CBACK 2'h1
`define ABAC_CP_SERIAL 2'h2
`define ABAC_CP_NOSER 2'h3

`endif

/* inc/abac_pkg.sv */
// Types shared by the block access control logic
// Assumes abac_defs.svh is on the include path.
`include "abac_defs.svh"
package abac_pkg;

  // Decoded fields of one block control word
  typedef struct packed {
    logic [7:0] base;
    logic [7:0] mask;
    logic enable;
    logic [1:0] priv;
    logic [1:0] uattr;
    logic [1:0] cpol;
    logic wprot;
  } abac_fields_t;

  // One access presented by a memory unit
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic privilege_code_bit;
    logic write;
    logic rmw;
    logic aligned;
    logic ext_xfer;
    logic cache_hit;
    logic line_dirty;
  } abac_access_t;

  // Attributes handed back for an access
  typedef struct packed {
    logic hit;
    logic [1:0] uattr;
    logic [1:0] cpol;
    logic wprot;
  } abac_attr_t;

  // Cache action chosen from the policy
  typedef struct packed {
    logic use_cache;
    logic fill_on_miss;
    logic write_mem;
    logic mark_dirty;
    logic inhibit;
    logic push_line;
    logic inval_line;
    logic serialize;
    logic no_interrupt;
    logic access_err;
  } abac_action_t;

  // Bus slave phase states
  typedef enum logic [1:0] {
    ABAC_ST_IDLE = 2'b01,
    ABAC_ST_DATA = 2'b10
  } abac_state_t;

endpackage : abac_pkg
